// *** hdl/lsa_pkg.sv ***
// Shared constants and types for the light sensor serial slave and sequencer
package lsa_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TIMEOUT_MS = 28;
  localparam int ASSESS_MS = 10;
  localparam int INT_SHORT_MS = 100;
  localparam int INT_LONG_MS = 800;
  localparam int OVERHEAD_MS = 3;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * CYC_PER_MS;
  localparam int ASSESS_CYC = ASSESS_MS * CYC_PER_MS;
  localparam int INT_SHORT_CYC = INT_SHORT_MS * CYC_PER_MS;
  localparam int INT_LONG_CYC = INT_LONG_MS * CYC_PER_MS;
  localparam int OVERHEAD_CYC = OVERHEAD_MS * CYC_PER_MS;

  localparam logic [6:0] SLAVE_ADDR = 7'h45;
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;

  // Configuration word layout
  localparam int CFG_RN_LSB = 12;
  localparam int CFG_CT_BIT = 11;
  localparam int CFG_M_LSB = 9;
  localparam int CFG_OVF_BIT = 8;
  localparam int CFG_CRF_BIT = 7;
  localparam logic [3:0] RN_RESET = 4'hC;
  localparam logic CT_RESET = 1'b1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  localparam logic [3:0] RN_AUTO = 4'hC;
  localparam logic [3:0] RANGE_MAX = 4'hB;
  localparam logic [11:0] LOW2_TH = 12'h100;
  localparam logic [11:0] LOW1_TH = 12'h400;
  localparam logic [11:0] HIGH_TH = 12'hC00;

  typedef enum logic [1:0] {
    LSA_M_SHUTDOWN = 2'b00,
    LSA_M_SINGLE = 2'b01,
    LSA_M_CONT = 2'b10,
    LSA_M_CONT2 = 2'b11
  } lsa_mode_t;

  typedef enum logic [2:0] {
    LSA_B_IDLE = 3'b000,
    LSA_B_ADDR = 3'b001,
    LSA_B_AACK = 3'b010,
    LSA_B_WRB = 3'b011,
    LSA_B_WACK = 3'b100,
    LSA_B_RDB = 3'b101,
    LSA_B_RACK = 3'b110
  } lsa_bus_t;

  typedef enum logic [1:0] {
    LSA_S_IDLE = 2'b00,
    LSA_S_ASSESS = 2'b01,
    LSA_S_INTEG = 2'b10,
    LSA_S_FINISH = 2'b11
  } lsa_seq_t;

  // Request to the light front end: start pulse opens a window
  typedef struct packed {
    logic start;
    logic assess;
    logic [3:0] range_sel;
  } lsa_afe_req_t;

  // Front end answer, sampled when the window closes
  typedef struct packed {
    logic overflow;
    logic [11:0] count;
  } lsa_afe_rsp_t;
endpackage

// *** hdl/lsa_light_sensor.sv ***
// Light sensor two-wire slave with auto-ranging measurement sequencer
//
// Contract
// - Clock line low for the timeout period resets the bus machine.
// - Address byte is seven fixed address bits plus direction; answer only on match.
// - Data falling while clock high is a start; transaction begins.
// - Data rising while clock high is a stop; return to idle.
// - Address bits sampled on clock rising edges; last bit selects read or write.
// - Ninth clock is acknowledge; receiver pulls data low; device acks its address.
// - Data change during clock high is always taken as start or stop.
// - Bytes shift most significant bit first, both directions.
// - Slave works at standard, fast and high speed clock rates.
// - Range select field at auto code enters automatic range selection.
// - Entering auto range runs a short assessment choosing the first range.
// - Low result in auto range lowers range by one or two.
// - High result in auto range raises range by exactly one.
// - Overflow in auto range aborts; aborted result never reaches result register. At maximum range the code stores the result and sets the overflow flag.
// - After overflow below maximum range, step up and restart measurement.
// - Integration runs over one of two selectable periods.
// - Power up in shutdown; no conversion until programmed active.
// - Continuous and single shot modes, selected over the bus.
// - Conversion time select one picks long period, zero short.
// - Result readable a fixed overhead after integration ends.
// - First written byte after write address loads the register pointer.
// - Sixteen bit registers move as two bytes, high byte first.
`timescale 1ns/1ps
module lsa_light_sensor
  import lsa_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int ASSESS_CYCLES = ASSESS_CYC,
  parameter int INT_SHORT_CYCLES = INT_SHORT_CYC,
  parameter int INT_LONG_CYCLES = INT_LONG_CYC,
  parameter int OVERHEAD_CYCLES = OVERHEAD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output lsa_afe_req_t afe_req,
  input wire lsa_afe_rsp_t afe_rsp,
  output logic active
);

  if (TIMEOUT_CYCLES < 2 || ASSESS_CYCLES < 1 || INT_SHORT_CYCLES < 1 ||
      INT_LONG_CYCLES < 1 || OVERHEAD_CYCLES < 1) begin : g_bad
    $error("lsa_light_sensor: cycle counts must be positive");
  end

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_f;
    logic sda_f;
    lsa_bus_t bus;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx_lo;
    logic rw;
    logic [1:0] byte_idx;
    logic [7:0] ptr;
    logic [7:0] wr_msb;
    logic [31:0] tmo_cnt;
    logic sda_drv;
    logic rd_ack_ok;
    logic [3:0] rn;
    logic ct;
    lsa_mode_t mode;
    logic ovf;
    logic crf;
    logic [15:0] result;
    lsa_seq_t seq;
    logic [31:0] seq_cnt;
    logic [3:0] cur_range;
    logic need_assess;
    logic afe_start;
    logic afe_assess;
    logic [15:0] pend_res;
  } lsa_state_t;

  lsa_state_t st_q;
  lsa_state_t st_d;

  localparam lsa_state_t ST_RESET = '{
    scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
    bus: LSA_B_IDLE, bit_cnt: 4'h0, shift: 8'h00, tx_lo: 8'h00,
    rw: 1'b0, byte_idx: 2'h0, ptr: PTR_RESULT, wr_msb: 8'h00,
    tmo_cnt: 32'h0000_0000, sda_drv: 1'b0, rd_ack_ok: 1'b0,
    rn: RN_RESET, ct: CT_RESET, mode: LSA_M_SHUTDOWN, ovf: 1'b0, crf: 1'b0,
    result: RESULT_RESET, seq: LSA_S_IDLE, seq_cnt: 32'h0000_0000,
    cur_range: RANGE_MAX, need_assess: 1'b1, afe_start: 1'b0,
    afe_assess: 1'b0, pend_res: 16'h0000
  };

  function automatic logic [3:0] msb_pos(input logic [11:0] v);
    logic [3:0] p;
    p = 4'h0;
    for (int i = 0; i < 12; i++) begin
      if (v[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

  function automatic logic [3:0] manual_range(input logic [3:0] rn);
    return (rn > RANGE_MAX) ? RANGE_MAX : rn;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic tmo_hit;
  logic [15:0] cfg_word;
  logic [15:0] tx_word;
  logic [31:0] int_cyc;
  logic auto_mode;
  logic [15:0] wr_word;
  logic cfg_wr;
  logic cfg_rd;
  logic [3:0] nxt_range;

  always_comb begin
    cfg_word = 16'h0000;
    cfg_word[CFG_RN_LSB +: 4] = st_q.rn;
    cfg_word[CFG_CT_BIT] = st_q.ct;
    cfg_word[CFG_M_LSB +: 2] = st_q.mode;
    cfg_word[CFG_OVF_BIT] = st_q.ovf;
    cfg_word[CFG_CRF_BIT] = st_q.crf;
    case (st_q.ptr)
      PTR_RESULT: tx_word = st_q.result;
      PTR_CONFIG: tx_word = cfg_word;
      default: tx_word = 16'h0000;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.afe_start = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    wr_word = {st_q.wr_msb, st_q.shift};
    nxt_range = st_q.cur_range;

    // Three stage sync; a level counts once stages two and three agree
    st_d.scl_s = {st_q.scl_s[1:0], scl_i};
    st_d.sda_s = {st_q.sda_s[1:0], sda_i};
    if (st_q.scl_s[1] == st_q.scl_s[2]) begin
      st_d.scl_f = st_q.scl_s[2];
    end
    if (st_q.sda_s[1] == st_q.sda_s[2]) begin
      st_d.sda_f = st_q.sda_s[2];
    end
    // fast sampling: 200 MHz filter tracks even high speed clock phases
    scl_rise = !st_q.scl_f && st_d.scl_f;
    scl_fall = st_q.scl_f && !st_d.scl_f;
    // any data edge under high clock is a condition
    start_cond = st_q.scl_f && st_d.scl_f && st_q.sda_f && !st_d.sda_f;
    stop_cond = st_q.scl_f && st_d.scl_f && !st_q.sda_f && st_d.sda_f;

    if (st_d.scl_f) begin
      st_d.tmo_cnt = 32'h0000_0000;
    end else if (st_q.tmo_cnt != 32'(TIMEOUT_CYCLES)) begin
      st_d.tmo_cnt = st_q.tmo_cnt + 32'h0000_0001;
    end
    tmo_hit = st_q.tmo_cnt == 32'(TIMEOUT_CYCLES - 1) && !st_d.scl_f;

    if (tmo_hit) begin
      st_d.bus = LSA_B_IDLE;
      st_d.sda_drv = 1'b0;
    end else if (start_cond) begin
      st_d.bus = LSA_B_ADDR;
      st_d.bit_cnt = 4'h0;
      st_d.byte_idx = 2'h0;
      st_d.sda_drv = 1'b0;
    end else if (stop_cond) begin
      st_d.bus = LSA_B_IDLE;
      st_d.sda_drv = 1'b0;
    end else if (scl_rise) begin
      case (st_q.bus)
        // sample on rising clock; shift in high bit first
        LSA_B_ADDR, LSA_B_WRB: begin
          st_d.shift = {st_q.shift[6:0], st_q.sda_f};
          st_d.bit_cnt = st_q.bit_cnt + 4'h1;
        end
        LSA_B_RACK: st_d.rd_ack_ok = !st_q.sda_f;
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st_q.bus)
        LSA_B_ADDR: begin
          if (st_q.bit_cnt == 4'h8) begin
            st_d.bit_cnt = 4'h0;
            if (st_q.shift[7:1] == SLAVE_ADDR) begin
              st_d.bus = LSA_B_AACK;
              st_d.rw = st_q.shift[0];
              st_d.sda_drv = 1'b1;
            end else begin
              st_d.bus = LSA_B_IDLE;
            end
          end
        end
        LSA_B_AACK, LSA_B_RACK: begin
          st_d.sda_drv = 1'b0;
          st_d.bit_cnt = 4'h0;
          if (st_q.bus == LSA_B_RACK && !st_q.rd_ack_ok) begin
            st_d.bus = LSA_B_IDLE;
          end else if (st_q.bus == LSA_B_RACK || st_q.rw) begin
            st_d.bus = LSA_B_RDB;
            st_d.bit_cnt = 4'h1;
            // high byte first, low byte latched with it
            if (st_q.byte_idx == 2'h0) begin
              st_d.shift = tx_word[15:8];
              st_d.tx_lo = tx_word[7:0];
              st_d.byte_idx = 2'h1;
              cfg_rd = st_q.ptr == PTR_CONFIG;
              // pull low for zero bits only
              st_d.sda_drv = !tx_word[15];
            end else begin
              st_d.shift = st_q.tx_lo;
              st_d.byte_idx = 2'h0;
              st_d.sda_drv = !st_q.tx_lo[7];
            end
          end else begin
            st_d.bus = LSA_B_WRB;
          end
        end
        LSA_B_RDB: begin
          if (st_q.bit_cnt == 4'h8) begin
            st_d.bus = LSA_B_RACK;
            st_d.sda_drv = 1'b0;
          end else begin
            st_d.shift = {st_q.shift[6:0], 1'b0};
            st_d.sda_drv = !st_q.shift[6];
            st_d.bit_cnt = st_q.bit_cnt + 4'h1;
          end
        end
        LSA_B_WRB: begin
          if (st_q.bit_cnt == 4'h8) begin
            st_d.bus = LSA_B_WACK;
            st_d.sda_drv = 1'b1;
            case (st_q.byte_idx)
              2'h0: st_d.ptr = st_q.shift;
              2'h1: st_d.wr_msb = st_q.shift;
              default: cfg_wr = st_q.ptr == PTR_CONFIG;
            endcase
            st_d.byte_idx = (st_q.byte_idx == 2'h2) ? 2'h1 : st_q.byte_idx + 2'h1;
          end
        end
        LSA_B_WACK: begin
          st_d.sda_drv = 1'b0;
          st_d.bus = LSA_B_WRB;
          st_d.bit_cnt = 4'h0;
        end
        default: st_d.sda_drv = 1'b0;
      endcase
    end

    // Flags clear on a config read; a completion in the same cycle wins below
    if (cfg_rd) begin
      st_d.ovf = 1'b0;
      st_d.crf = 1'b0;
    end
    if (cfg_wr) begin
      st_d.rn = wr_word[CFG_RN_LSB +: 4];
      st_d.ct = wr_word[CFG_CT_BIT];
      st_d.mode = lsa_mode_t'(wr_word[CFG_M_LSB +: 2]);
      // fresh assessment when auto range is newly chosen
      if (wr_word[CFG_RN_LSB +: 4] == RN_AUTO && st_q.rn != RN_AUTO) begin
        st_d.need_assess = 1'b1;
      end
    end

    auto_mode = st_d.rn == RN_AUTO;
    int_cyc = st_d.ct ? 32'(INT_LONG_CYCLES) : 32'(INT_SHORT_CYCLES);
    if (st_q.seq_cnt != 32'h0000_0000) begin
      st_d.seq_cnt = st_q.seq_cnt - 32'h0000_0001;
    end

    if (st_d.mode == LSA_M_SHUTDOWN) begin
      st_d.seq = LSA_S_IDLE;
    end else begin
      case (st_q.seq)
        // leaves idle only once programmed active
        LSA_S_IDLE: begin
          st_d.afe_start = 1'b1;
          if (auto_mode && st_q.need_assess) begin
            st_d.seq = LSA_S_ASSESS;
            st_d.cur_range = RANGE_MAX;
            st_d.afe_assess = 1'b1;
            st_d.seq_cnt = 32'(ASSESS_CYCLES - 1);
          end else begin
            st_d.seq = LSA_S_INTEG;
            st_d.afe_assess = 1'b0;
            st_d.cur_range = auto_mode ? st_q.cur_range : manual_range(st_d.rn);
            st_d.seq_cnt = int_cyc - 32'h0000_0001;
          end
        end
        LSA_S_ASSESS: begin
          if (st_q.seq_cnt == 32'h0000_0000) begin
            // first full range from assessment level
            st_d.cur_range = afe_rsp.overflow ? RANGE_MAX : msb_pos(afe_rsp.count);
            st_d.need_assess = 1'b0;
            st_d.afe_assess = 1'b0;
            st_d.afe_start = 1'b1;
            st_d.seq = LSA_S_INTEG;
            st_d.seq_cnt = int_cyc - 32'h0000_0001;
          end
        end
        LSA_S_INTEG: begin
          if (st_q.seq_cnt == 32'h0000_0000) begin
            if (afe_rsp.overflow && auto_mode && st_q.cur_range < RANGE_MAX) begin
              st_d.cur_range = st_q.cur_range + 4'h1;
              st_d.afe_start = 1'b1;
              st_d.seq_cnt = int_cyc - 32'h0000_0001;
            end else begin
              st_d.pend_res = {st_q.cur_range, afe_rsp.count};
              if (auto_mode) begin
                // step down by two or one, or up by one on a high count
                if (afe_rsp.count < LOW2_TH && st_q.cur_range > 4'h1) begin
                  nxt_range = st_q.cur_range - 4'h2;
                end else if (afe_rsp.count < LOW1_TH && st_q.cur_range > 4'h0) begin
                  nxt_range = st_q.cur_range - 4'h1;
                end else if (afe_rsp.count >= HIGH_TH && st_q.cur_range < RANGE_MAX) begin
                  nxt_range = st_q.cur_range + 4'h1;
                end
              end
              st_d.cur_range = nxt_range;
              if (afe_rsp.overflow) begin
                st_d.ovf = 1'b1;
              end
              // fixed overhead before data is readable
              st_d.seq = LSA_S_FINISH;
              st_d.seq_cnt = 32'(OVERHEAD_CYCLES - 1);
            end
          end
        end
        LSA_S_FINISH: begin
          if (st_q.seq_cnt == 32'h0000_0000) begin
            st_d.result = st_q.pend_res;
            st_d.crf = 1'b1;
            st_d.seq = LSA_S_IDLE;
            // single shot falls back to shutdown
            if (st_d.mode == LSA_M_SINGLE) begin
              st_d.mode = LSA_M_SHUTDOWN;
            end
          end
        end
        default: st_d.seq = LSA_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // open drain: output always low, enable does the work
  assign sda_o = 1'b0;
  assign sda_oe = st_q.sda_drv;
  assign afe_req = '{start: st_q.afe_start, assess: st_q.afe_assess, range_sel: st_q.cur_range};
  assign active = st_q.seq != LSA_S_IDLE;

endmodule

// *** verification/lsa_light_sensor_monitor.sv ***
// Checker for the light sensor bus pins and front-end requests
`timescale 1ns/1ps
module lsa_light_sensor_monitor
  import lsa_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = 200,
  parameter int ASSESS_CYCLES = 20
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire lsa_afe_req_t afe_req,
  input wire logic active
);
  logic [15:0] low_q;
  logic [15:0] gap_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Saturating counts: clock-low run and cycles since last start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_q <= 16'h0000;
      gap_q <= 16'hFFFF;
    end else begin
      low_q <= scl_i ? 16'h0000 : low_q + {15'h0000, ~&low_q};
      gap_q <= afe_req.start ? 16'h0001 : gap_q + {15'h0000, ~&gap_q};
    end
  end
  a_drive_low_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_oe_clock_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data pin changed while clock high");
  // Margin covers the input synchroniser
  a_timeout_free: assert property (low_q > TIMEOUT_CYCLES + 8 |-> !sda_oe)
    else $error("data pin held after bus timeout");
  a_start_one_cycle: assert property (afe_req.start |=> !afe_req.start)
    else $error("start longer than one cycle");
  a_start_when_active: assert property (afe_req.start |-> active)
    else $error("conversion started while inactive");
  a_assess_top_range: assert property (afe_req.start && afe_req.assess |-> afe_req.range_sel == RANGE_MAX)
    else $error("assessment not at top range");
  a_range_capped: assert property (afe_req.start |-> afe_req.range_sel <= RANGE_MAX)
    else $error("range above maximum");
  a_window_spacing: assert property (afe_req.start |-> gap_q >= ASSESS_CYCLES)
    else $error("window shorter than assessment");
  c_assess: cover property (afe_req.start && afe_req.assess);
  c_ack: cover property ($rose(sda_oe));
  c_timeout: cover property (low_q == TIMEOUT_CYCLES + 9);
endmodule
bind lsa_light_sensor lsa_light_sensor_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES), .ASSESS_CYCLES(ASSESS_CYCLES))
  lsa_light_sensor_monitor_inst (.clk(clk), .reset_n(reset_n), .scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .afe_req(afe_req), .active(active));

// *** verification/lsa_i2c_master_model.sv ***
// Two-wire bus master model: drives clock, open-drain data
`timescale 1ns/1ps
module lsa_i2c_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic q(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start_c();
    sda_m = 1'b1;
    q(6);
    scl = 1'b1;
    q(6);
    sda_m = 1'b0;
    q(6);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    sda_m = 1'b0;
    q(6);
    scl = 1'b1;
    q(6);
    sda_m = 1'b1;
    q(6);
  endtask
  // data moves only while clock low, 125 ns bit
  task automatic clk_bit(input logic b, output logic s);
    q(3);
    sda_m = b;
    q(9);
    scl = 1'b1;
    q(6);
    s = sda;
    q(7);
    scl = 1'b0;
  endtask
  // eight bits high first, then acknowledge slot
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic rd_byte(output logic [7:0] d, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
  endtask
endmodule

// *** verification/lsa_light_sensor_tb_top.sv ***
// Self-checking bench for the light sensor block
`timescale 1ns/1ps
module lsa_light_sensor_tb_top
  import lsa_pkg::*;
;
  localparam int TO = 200;
  localparam int AS = 20;
  localparam int SH = 50;
  localparam int LG = 100;
  localparam int OV = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic active;
  lsa_afe_req_t afe_req;
  lsa_afe_rsp_t afe_rsp = '0;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int last_st = 0;
  // Pull-up wire: low if either party pulls
  wire sda = sda_m & ~(sda_oe & ~sda_o);
  initial forever #2.5 clk = ~clk;
  lsa_light_sensor #(.TIMEOUT_CYCLES(TO), .ASSESS_CYCLES(AS), .INT_SHORT_CYCLES(SH), .INT_LONG_CYCLES(LG),
    .OVERHEAD_CYCLES(OV)) lsa_light_sensor_inst (.clk(clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .afe_req(afe_req), .afe_rsp(afe_rsp), .active(active));
  lsa_i2c_master_model lsa_i2c_master_model_inst (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic gap_chk(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) begin
      n_errors++;
      $display("ERROR at %0t: gap %h outside %h to %h", $time, g, lo, hi);
    end
  endtask
  task automatic wb(input logic [7:0] b);
    logic a;
    lsa_i2c_master_model_inst.wr_byte(b, a);
    chk(16'(a), 16'h0001);
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [15:0] d);
    lsa_i2c_master_model_inst.start_c();
    wb(8'h8A);
    wb(p);
    wb(d[15:8]);
    wb(d[7:0]);
    lsa_i2c_master_model_inst.stop_c();
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] d;
    lsa_i2c_master_model_inst.start_c();
    wb(8'h8A);
    wb(p);
    lsa_i2c_master_model_inst.start_c();
    wb(8'h8B);
    lsa_i2c_master_model_inst.rd_byte(d[15:8], 1'b0);
    lsa_i2c_master_model_inst.rd_byte(d[7:0], 1'b1);
    lsa_i2c_master_model_inst.stop_c();
    chk(d, e);
  endtask
  // Waits for a window, checks its request, loads the light answer
  task automatic win(input logic as, input logic [3:0] r, input logic ov, input logic [11:0] c, output int g);
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (afe_req.start !== 1'b1 && k < 2000);
    chk(16'(afe_req.start), 16'h0001);
    chk(16'(afe_req.assess), 16'(as));
    chk(16'(afe_req.range_sel), 16'(r));
    g = cyc - last_st;
    last_st = cyc;
    afe_rsp = {ov, c};
  endtask
  task automatic t_reset();
    chk(16'(sda_oe), 16'h0000);
    chk(16'(afe_req), 16'h000B);
    rd_chk(PTR_CONFIG, 16'hC800);
    rd_chk(PTR_RESULT, 16'h0000);
    chk(16'(active), 16'h0000);
    $display("Test reset done");
  endtask
  task automatic t_addr();
    logic a;
    for (int i = 0; i < 2; i++) begin
      lsa_i2c_master_model_inst.start_c();
      lsa_i2c_master_model_inst.wr_byte(i ? 8'h8C : 8'h0A, a);
      lsa_i2c_master_model_inst.stop_c();
      chk(16'(a), 16'h0000);
    end
    // Unmapped pointer reads back as zero
    rd_chk(8'h02, 16'h0000);
    $display("Test address done");
  endtask
  task automatic t_manual();
    int g;
    fork
      reg_wr(PTR_CONFIG, 16'h5400);
      begin
        win(1'b0, 4'h5, 1'b0, 12'h123, g);
        win(1'b0, 4'h5, 1'b0, 12'h123, g);
        gap_chk(g, SH + OV, SH + OV + 3);
      end
    join
    reg_wr(PTR_CONFIG, 16'h5000);
    chk(16'(active), 16'h0000);
    rd_chk(PTR_RESULT, 16'h5123);
    $display("Test manual done");
  endtask
  task automatic t_timeout();
    lsa_i2c_master_model_inst.start_c();
    wb(8'h8B);
    lsa_i2c_master_model_inst.q(100);
    chk(16'(sda_oe), 16'h0001);
    lsa_i2c_master_model_inst.q(TO + 60);
    chk(16'(sda_oe), 16'h0000);
    lsa_i2c_master_model_inst.stop_c();
    rd_chk(PTR_CONFIG, 16'h5080);
    $display("Test timeout done");
  endtask
  task automatic t_auto();
    int g;
    fork
      // Second continuous mode code, not used elsewhere
      reg_wr(PTR_CONFIG, 16'hCE00);
      begin
        win(1'b1, 4'hB, 1'b0, 12'h400, g);
        win(1'b0, 4'hA, 1'b0, 12'h080, g);
        gap_chk(g, AS, AS + 3);
        win(1'b0, 4'h8, 1'b0, 12'hC00, g);
        gap_chk(g, LG + OV, LG + OV + 3);
        win(1'b0, 4'h9, 1'b1, 12'hFFF, g);
        win(1'b0, 4'hA, 1'b0, 12'h800, g);
        gap_chk(g, LG, LG + 3);
        win(1'b0, 4'hA, 1'b0, 12'h800, g);
      end
    join
    reg_wr(PTR_CONFIG, 16'hC800);
    chk(16'(active), 16'h0000);
    $display("Test auto done");
  endtask
  task automatic t_single();
    int g;
    fork
      reg_wr(PTR_CONFIG, 16'hCA00);
      win(1'b0, 4'hA, 1'b0, 12'h345, g);
    join
    repeat (LG + OV + 20) @(negedge clk);
    chk(16'(active), 16'h0000);
    rd_chk(PTR_RESULT, 16'hA345);
    rd_chk(PTR_CONFIG, 16'hC880);
    $display("Test single done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_addr();
    t_manual();
    t_timeout();
    t_auto();
    t_single();
    complete_run();
  end
endmodule
